// ---- fsepr_pkg.sv ----
// Shared constants and types for the flash sector erase/program/read sequencer.
package fsepr_pkg;
  // Register indices on the core-side register port.
  localparam logic [1:0] REG_OP_CONTROL = 2'h0;
  localparam logic [1:0] REG_UNLOCK_KEY = 2'h1;
  localparam logic [1:0] REG_SECT_HIGH = 2'h2;
  localparam logic [1:0] REG_SECT_LOW = 2'h3;
  // Key and operation codes.
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;
  localparam logic [7:0] LOCK_KEY = 8'h00;
  localparam logic [7:0] OP_ERASE = 8'ha1;
  localparam logic [7:0] OP_PROGRAM = 8'h51;
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam int ERASE_STATUS_BIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Array geometry.
  localparam int SECTORS = 512;
  localparam int SECTOR_BYTES = 128;
  localparam int SECT_LOW_IGNORED = 7;
  // Timing.
  localparam int CLOCK_HZ = 40000000;
  localparam int ERASE_TIME_MS = 10;
  localparam int ERASE_CYCLES = (CLOCK_HZ / 1000) * ERASE_TIME_MS;
  localparam int PROGRAM_CYCLES = 4;
  localparam int ERASE_NOPS = 2;
  localparam int PROGRAM_NOPS = 1;
  typedef enum {FSEPR_IDLE, FSEPR_ERASE, FSEPR_PROGRAM} fsepr_state_e;
  typedef enum {FSEPR_H_IDLE, FSEPR_H_WR, FSEPR_H_WAIT, FSEPR_H_NOP, FSEPR_H_CHECK,
    FSEPR_H_LOCK, FSEPR_H_DONE} fsepr_host_e;
endpackage : fsepr_pkg

// ---- fsepr_if.sv ----
// Core-to-sequencer link: register port, table access port and interrupt abort.
interface fsepr_if;
  logic reg_wr;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic tbl_req;
  logic tbl_write;
  logic [15:0] tbl_addr;
  logic [7:0] tbl_wdata;
  logic [7:0] tbl_rdata;
  logic tbl_done;
  logic busy;
  logic irq_pending;
  modport device (
    input reg_wr, reg_addr, reg_wdata, tbl_req, tbl_write, tbl_addr, tbl_wdata, irq_pending,
    output reg_rdata, tbl_rdata, tbl_done, busy
  );
  modport core (
    output reg_wr, reg_addr, reg_wdata, tbl_req, tbl_write, tbl_addr, tbl_wdata, irq_pending,
    input reg_rdata, tbl_rdata, tbl_done, busy
  );
endinterface : fsepr_if

// ---- fsepr_device.sv ----
// Flash sequencer device end: key, sector registers, erase/program engine and array.
// Behaviour
// - Erase only in user program mode, per sector
// - 512 sectors of 128 bytes each
// - Core erases sector before writing bytes
// - Erase lasts at least 10 ms
// - No erase in tool programming modes
// - Core sets only aborting interrupts before erase
// - Key A5 opens user program mode first
// - Writing A1 starts addressed sector erase
// - Core writes 00 to key afterwards
// - Erase status reported in control bit 3
// - Core inserts two or one no-ops
// - Program bytewise inside loaded sector
// - Table store writes byte, 128 per setting
// - Writing 51 selects byte programming mode
// - Core supplies 16-bit indirect byte address
// - Table load reads without key or mode
// - Failed identity check clears key, then control
// - Status zero success, one failure
// - Pending enabled interrupt aborts erase
// - Reset clears key; other values lock
// - Sector low bits 6..0 ignored
module fsepr_device #(
  parameter int ERASE_CYCLES = fsepr_pkg::ERASE_CYCLES,
  parameter int ADDR_BITS = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tool_mode,
  fsepr_if.device link
);
  localparam int DEPTH = 1 << ADDR_BITS;
  logic [7:0] flash_op_control;
  logic [7:0] flash_unlock_key;
  logic [7:0] sector_addr_high;
  logic [7:0] sector_addr_low;
  logic erase_fail;
  logic [7:0] prog_count;
  logic [31:0] timer;
  logic [7:0] mem [DEPTH];
  fsepr_pkg::fsepr_state_e state;
  logic unlocked;
  logic [15:0] sector_base;
  logic in_sector;
  logic op_wr;
  logic tool_meta;
  logic tool_sync;
  logic erase_go;
  logic store_ok;
  logic next_busy;

  assign unlocked = flash_unlock_key == fsepr_pkg::UNLOCK_KEY;
  // The array holds 512 sectors; the low seven sector bits never select anything.
  assign sector_base = {sector_addr_high, sector_addr_low[7], 7'h00};
  assign in_sector = link.tbl_addr[15:fsepr_pkg::SECT_LOW_IGNORED] ==
    sector_base[15:fsepr_pkg::SECT_LOW_IGNORED];
  assign op_wr = link.reg_wr && link.reg_addr == fsepr_pkg::REG_OP_CONTROL;
  assign erase_go = op_wr && state == fsepr_pkg::FSEPR_IDLE && unlocked && !tool_sync &&
    link.reg_wdata == fsepr_pkg::OP_ERASE;
  // A store is taken only once per request, with key, code, sector and room all in place.
  assign store_ok = link.tbl_req && link.tbl_write && !link.tbl_done && unlocked && in_sector &&
    flash_op_control == fsepr_pkg::OP_PROGRAM && prog_count != 8'(fsepr_pkg::SECTOR_BYTES);
  // Busy follows the engine's next state, so it stands exactly while the engine is active.
  assign next_busy = erase_go || (state == fsepr_pkg::FSEPR_IDLE && store_ok) ||
    (state == fsepr_pkg::FSEPR_ERASE && !link.irq_pending && timer != 32'h0) ||
    (state == fsepr_pkg::FSEPR_PROGRAM && timer != 32'h0);

  // Tool mode comes from a pin outside this clock, so two flops guard against metastability.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tool_meta <= 1'b0;
      tool_sync <= 1'b0;
    end else begin
      tool_meta <= tool_mode;
      tool_sync <= tool_meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_unlock_key <= fsepr_pkg::RESET_BYTE;
      sector_addr_high <= fsepr_pkg::RESET_BYTE;
      sector_addr_low <= fsepr_pkg::RESET_BYTE;
    end else if (link.reg_wr && state == fsepr_pkg::FSEPR_IDLE) begin
      if (link.reg_addr == fsepr_pkg::REG_UNLOCK_KEY) begin
        flash_unlock_key <= link.reg_wdata;
      end
      if (link.reg_addr == fsepr_pkg::REG_SECT_HIGH) begin
        sector_addr_high <= link.reg_wdata;
      end
      if (link.reg_addr == fsepr_pkg::REG_SECT_LOW) begin
        sector_addr_low <= link.reg_wdata;
      end
    end
  end

  // Control byte: opcodes land only while unlocked; zero may be written whenever the engine is idle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_op_control <= fsepr_pkg::OP_NONE;
    end else if (op_wr && state == fsepr_pkg::FSEPR_IDLE) begin
      if (link.reg_wdata == fsepr_pkg::OP_NONE) begin
        flash_op_control <= fsepr_pkg::OP_NONE;
      end else if (unlocked && (link.reg_wdata == fsepr_pkg::OP_PROGRAM ||
          (link.reg_wdata == fsepr_pkg::OP_ERASE && !tool_sync))) begin
        flash_op_control <= link.reg_wdata;
      end
    end else if (state == fsepr_pkg::FSEPR_ERASE && link.irq_pending) begin
      flash_op_control <= fsepr_pkg::OP_NONE;
    end else if (state == fsepr_pkg::FSEPR_ERASE && timer == 32'h0) begin
      flash_op_control <= fsepr_pkg::OP_NONE;
    end
  end

  // Operation engine. Erase is started by the op write itself.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsepr_pkg::FSEPR_IDLE;
      timer <= 32'h0;
      erase_fail <= 1'b0;
    end else begin
      case (state)
        fsepr_pkg::FSEPR_IDLE: begin
          if (erase_go) begin
            state <= fsepr_pkg::FSEPR_ERASE;
            timer <= 32'(ERASE_CYCLES - 1);
            erase_fail <= 1'b0;
          end else if (store_ok) begin
            state <= fsepr_pkg::FSEPR_PROGRAM;
            timer <= 32'(fsepr_pkg::PROGRAM_CYCLES - 1);
          end
        end
        fsepr_pkg::FSEPR_ERASE: begin
          if (link.irq_pending) begin
            state <= fsepr_pkg::FSEPR_IDLE;
            erase_fail <= 1'b1;
          end else if (timer == 32'h0) begin
            state <= fsepr_pkg::FSEPR_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        fsepr_pkg::FSEPR_PROGRAM: begin
          if (timer == 32'h0) begin
            state <= fsepr_pkg::FSEPR_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: state <= fsepr_pkg::FSEPR_IDLE;
      endcase
    end
  end

  // Bytes written since the sector registers were last loaded; full stops further writes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_count <= 8'h00;
    end else if (link.reg_wr && state == fsepr_pkg::FSEPR_IDLE &&
        (link.reg_addr == fsepr_pkg::REG_SECT_HIGH || link.reg_addr == fsepr_pkg::REG_SECT_LOW)) begin
      prog_count <= 8'h00;
    end else if (state == fsepr_pkg::FSEPR_PROGRAM && timer == 32'h0 &&
        prog_count != 8'(fsepr_pkg::SECTOR_BYTES)) begin
      prog_count <= prog_count + 8'h1;
    end
  end

  // Array. Erase leaves 8'hff; programming can only clear bits, like real cells.
  always_ff @(posedge clock) begin
    if (state == fsepr_pkg::FSEPR_ERASE && timer == 32'h0 && !link.irq_pending) begin
      for (int i = 0; i < fsepr_pkg::SECTOR_BYTES; i++) begin
        mem[sector_base + 16'(i)] <= 8'hff;
      end
    end else if (state == fsepr_pkg::FSEPR_PROGRAM && timer == 32'h0) begin
      mem[link.tbl_addr] <= mem[link.tbl_addr] & link.tbl_wdata;
    end
  end

  // Answers. Reads need no key; any table access waits while an operation runs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.tbl_done <= 1'b0;
      link.tbl_rdata <= 8'h00;
      link.busy <= 1'b0;
      link.reg_rdata <= 8'h00;
    end else begin
      link.busy <= next_busy;
      link.tbl_done <= 1'b0;
      if (link.tbl_req && !link.tbl_done) begin
        if (!link.tbl_write && state == fsepr_pkg::FSEPR_IDLE) begin
          link.tbl_rdata <= mem[link.tbl_addr];
          link.tbl_done <= 1'b1;
        end else if (link.tbl_write && state == fsepr_pkg::FSEPR_PROGRAM && timer == 32'h0) begin
          link.tbl_done <= 1'b1;
        end else if (link.tbl_write && state == fsepr_pkg::FSEPR_IDLE && !store_ok) begin
          link.tbl_done <= 1'b1; // Refused store completes without effect.
        end
      end
      case (link.reg_addr)
        fsepr_pkg::REG_OP_CONTROL: link.reg_rdata <= {flash_op_control[7:4], erase_fail,
          flash_op_control[2:0]};
        fsepr_pkg::REG_UNLOCK_KEY: link.reg_rdata <= flash_unlock_key;
        fsepr_pkg::REG_SECT_HIGH: link.reg_rdata <= sector_addr_high;
        default: link.reg_rdata <= sector_addr_low;
      endcase
    end
  end
endmodule : fsepr_device

// ---- fsepr_core.sv ----
// Core end: runs erase, program and read sequences on the sequencer as the core would.
module fsepr_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [1:0] op,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic id_ok,
  input wire logic irq_in,
  output logic done,
  output logic fail,
  output logic [7:0] rdata,
  fsepr_if.core link
);
  fsepr_pkg::fsepr_host_e state;
  logic [3:0] step;
  logic [1:0] nops;
  logic [1:0] cur_op;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsepr_pkg::FSEPR_H_IDLE;
      step <= 4'h0;
      nops <= 2'h0;
      cur_op <= 2'h0;
      done <= 1'b0;
      fail <= 1'b0;
      rdata <= 8'h00;
      link.reg_wr <= 1'b0;
      link.reg_addr <= 2'h0;
      link.reg_wdata <= 8'h00;
      link.tbl_req <= 1'b0;
      link.tbl_write <= 1'b0;
      link.tbl_addr <= 16'h0;
      link.tbl_wdata <= 8'h00;
      link.irq_pending <= 1'b0;
    end else begin
      done <= 1'b0;
      link.reg_wr <= 1'b0;
      link.irq_pending <= irq_in;
      case (state)
        fsepr_pkg::FSEPR_H_IDLE: begin
          if (start) begin
            cur_op <= op;
            link.tbl_addr <= addr;
            link.tbl_wdata <= wdata;
            step <= 4'h0;
            state <= op == 2'h0 ? fsepr_pkg::FSEPR_H_WAIT : fsepr_pkg::FSEPR_H_WR;
            link.tbl_req <= op == 2'h0;
            link.tbl_write <= 1'b0;
          end
        end
        fsepr_pkg::FSEPR_H_WR: begin
          link.reg_wr <= 1'b1;
          step <= step + 4'h1;
          case (step)
            4'h0: begin
              link.reg_addr <= fsepr_pkg::REG_UNLOCK_KEY;
              link.reg_wdata <= fsepr_pkg::UNLOCK_KEY;
            end
            4'h1: begin
              link.reg_addr <= fsepr_pkg::REG_SECT_HIGH;
              link.reg_wdata <= link.tbl_addr[15:8];
            end
            4'h2: begin
              link.reg_addr <= fsepr_pkg::REG_SECT_LOW;
              // The raw low byte goes out; the device itself drops its low seven bits.
              link.reg_wdata <= link.tbl_addr[7:0];
            end
            default: begin
              link.reg_addr <= fsepr_pkg::REG_OP_CONTROL;
              if (!id_ok) begin
                link.reg_addr <= fsepr_pkg::REG_UNLOCK_KEY;
                link.reg_wdata <= fsepr_pkg::LOCK_KEY;
                fail <= 1'b1;
                state <= fsepr_pkg::FSEPR_H_LOCK;
              end else begin
                link.reg_wdata <= cur_op == 2'h1 ? fsepr_pkg::OP_ERASE :
                  fsepr_pkg::OP_PROGRAM;
                nops <= cur_op == 2'h1 ? 2'(fsepr_pkg::ERASE_NOPS) : 2'(fsepr_pkg::PROGRAM_NOPS);
                state <= fsepr_pkg::FSEPR_H_NOP;
              end
            end
          endcase
        end
        fsepr_pkg::FSEPR_H_NOP: begin
          nops <= nops - 2'h1;
          if (nops == 2'h1) begin
            // The store trails the program code so the device already holds that code.
            state <= fsepr_pkg::FSEPR_H_WAIT;
            link.tbl_req <= cur_op == 2'h2;
            link.tbl_write <= cur_op == 2'h2;
          end
        end
        fsepr_pkg::FSEPR_H_WAIT: begin
          if (link.tbl_done) begin
            link.tbl_req <= 1'b0;
            rdata <= link.tbl_rdata;
          end
          if ((cur_op == 2'h1 && !link.busy) || link.tbl_done) begin
            state <= cur_op == 2'h0 ? fsepr_pkg::FSEPR_H_DONE : fsepr_pkg::FSEPR_H_CHECK;
            link.reg_wr <= cur_op != 2'h0;
            link.reg_addr <= fsepr_pkg::REG_UNLOCK_KEY;
            link.reg_wdata <= fsepr_pkg::LOCK_KEY;
          end
        end
        fsepr_pkg::FSEPR_H_CHECK: begin
          // Read data is registered, so the status stands one cycle after its index.
          link.reg_addr <= fsepr_pkg::REG_OP_CONTROL;
          if (link.reg_addr == fsepr_pkg::REG_OP_CONTROL) begin
            state <= fsepr_pkg::FSEPR_H_DONE;
          end
        end
        fsepr_pkg::FSEPR_H_LOCK: begin
          link.reg_wr <= 1'b1;
          link.reg_addr <= fsepr_pkg::REG_OP_CONTROL;
          link.reg_wdata <= fsepr_pkg::OP_NONE;
          state <= fsepr_pkg::FSEPR_H_DONE;
        end
        fsepr_pkg::FSEPR_H_DONE: begin
          if (cur_op == 2'h1 && !fail) begin
            fail <= link.reg_rdata[fsepr_pkg::ERASE_STATUS_BIT];
          end
          done <= 1'b1;
          state <= fsepr_pkg::FSEPR_H_IDLE;
        end
        default: state <= fsepr_pkg::FSEPR_H_IDLE;
      endcase
      if (start && state == fsepr_pkg::FSEPR_H_IDLE) begin
        fail <= 1'b0;
      end
    end
  end
endmodule : fsepr_core

// ---- fsepr_props.sv ----
// Concurrent checks on the link between the core end and the sequencer device end.
module fsepr_props #(
  parameter int ERASE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tool_mode,
  input wire logic reg_wr,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic tbl_req,
  input wire logic tbl_write,
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_done,
  input wire logic busy,
  input wire logic irq_pending
);
  logic key_open;
  logic prog_mode;
  logic ers;
  logic irq_seen;
  logic stat_exp;
  int unsigned run;
  // Writes during busy are dropped by the device, so the mirror drops them too.
  wire op_wr = reg_wr && reg_addr == fsepr_pkg::REG_OP_CONTROL && !busy;
  wire erase_go = op_wr && reg_wdata == fsepr_pkg::OP_ERASE && key_open && !tool_mode;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) key_open <= 1'b0;
    else if (reg_wr && reg_addr == fsepr_pkg::REG_UNLOCK_KEY && !busy)
      key_open <= reg_wdata == fsepr_pkg::UNLOCK_KEY;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prog_mode <= 1'b0;
    else if (op_wr && key_open) prog_mode <= reg_wdata == fsepr_pkg::OP_PROGRAM;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) run <= 0;
    else run <= busy ? run + 1 : 0;
  end
  // Expected status is only trusted once the erase has fully wound down.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ers <= 1'b0;
      irq_seen <= 1'b0;
      stat_exp <= 1'b0;
    end else if (erase_go) begin
      ers <= 1'b1;
      irq_seen <= 1'b0;
    end else if (ers && busy && irq_pending) begin
      irq_seen <= 1'b1;
    end else if (ers && !busy && run != 0) begin
      ers <= 1'b0;
      stat_exp <= irq_seen;
    end
  end
  a_erase_start: assert property (erase_go |=> busy)
    else $error("erase did not start");
  a_erase_refused: assert property (op_wr && reg_wdata == fsepr_pkg::OP_ERASE
    && !(key_open && !tool_mode) |=> !busy) else $error("locked erase started");
  a_erase_length: assert property (ers && !busy && run != 0 && !irq_seen
    |-> run == ERASE_CYCLES) else $error("erase length wrong");
  a_abort_quick: assert property (ers && busy && irq_pending |-> ##[1:3] !busy)
    else $error("erase not aborted");
  a_status_bit: assert property (reg_addr == fsepr_pkg::REG_OP_CONTROL && !ers && !erase_go
    |=> reg_rdata[fsepr_pkg::ERASE_STATUS_BIT] == $past(stat_exp)) else $error("status bit wrong");
  a_read_answer: assert property ($rose(tbl_req) && !tbl_write && !busy |=> tbl_done)
    else $error("read not answered");
  a_done_pulse: assert property (tbl_done |=> !tbl_done)
    else $error("done longer than a cycle");
  a_prog_time: assert property ($rose(tbl_req) && tbl_write && key_open && prog_mode && !busy
    |-> ##5 tbl_done) else $error("store timing wrong");
  a_rdata_hold: assert property ($changed(tbl_rdata) |-> tbl_done)
    else $error("read data moved");
endmodule : fsepr_props

// ---- tb_top.sv ----
// Self-checking bench: core end and device end joined, driven from the core user side.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SIM_ERASE = 20;
  logic clock;
  logic rst_n;
  logic tool_mode;
  logic start;
  logic [1:0] op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic id_ok;
  logic irq_in;
  logic done;
  logic fail;
  logic [7:0] rdata;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  fsepr_if link();
  fsepr_device #(.ERASE_CYCLES(SIM_ERASE)) i_fsepr_device (.clock(clock), .rst_n(rst_n),
    .tool_mode(tool_mode), .link(link));
  fsepr_core i_fsepr_core (.clock(clock), .rst_n(rst_n), .start(start), .op(op), .addr(addr),
    .wdata(wdata), .id_ok(id_ok), .irq_in(irq_in), .done(done), .fail(fail), .rdata(rdata),
    .link(link));
  fsepr_props #(.ERASE_CYCLES(SIM_ERASE)) u_props (.clock(clock), .rst_n(rst_n),
    .tool_mode(tool_mode), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .tbl_req(link.tbl_req),
    .tbl_write(link.tbl_write), .tbl_rdata(link.tbl_rdata), .tbl_done(link.tbl_done),
    .busy(link.busy), .irq_pending(link.irq_pending));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Sequences run long when erasing, so the wait bound covers a full erase.
  task automatic do_op(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    op <= o;
    addr <= a;
    wdata <= d;
    start <= 1'b1;
    do begin
      @(posedge clock);
      start <= 1'b0;
      #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) chk(8'h01, 8'h00);
  endtask : do_op
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    do_op(2'h0, a, 8'h00);
    chk(rdata, exp);
  endtask : rd
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    tool_mode = 1'b0;
    start = 1'b0;
    op = 2'h0;
    addr = 16'h0000;
    wdata = 8'h00;
    id_ok = 1'b1;
    irq_in = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    do_op(2'h1, 16'h1044, 8'h00);
    chk({7'h00, fail}, 8'h00);
    rd(16'h107f, 8'hff);
    rd(16'h1000, 8'hff);
    do_op(2'h2, 16'h1004, 8'h78);
    rd(16'h1004, 8'h78);
    do_op(2'h2, 16'h1004, 8'h0f);
    rd(16'h1004, 8'h08);
    fork
      do_op(2'h1, 16'h1000, 8'h00);
      begin
        repeat (12) @(posedge clock);
        irq_in <= 1'b1;
      end
    join
    irq_in <= 1'b0;
    chk({7'h00, fail}, 8'h01);
    rd(16'h1004, 8'h08);
    tool_mode <= 1'b1;
    do_op(2'h1, 16'h1000, 8'h00);
    tool_mode <= 1'b0;
    rd(16'h1004, 8'h08);
    id_ok <= 1'b0;
    do_op(2'h1, 16'h1000, 8'h00);
    id_ok <= 1'b1;
    rd(16'h1004, 8'h08);
    report_and_stop();
  end
endmodule : tb_top
